// *** hdl/dpb_pkg.sv ***
package dpb_pkg;
   // -----------------------------------------------------------------
   // Geometry
   // -----------------------------------------------------------------
   localparam int ENTRIES = 8;
   localparam int ENT_W = 3;
   localparam int SLOT_W = 4;
   localparam int SLOTS = 16;
   localparam int GEN_W = 3;
   localparam int HALF_SHIFT = 6;
   localparam int LINE_W = 26;
   localparam logic [31:0] DIRECT_LO = 32'h0c000000;
   localparam logic [3:0] ALIAS_HI = 4'h1;

   // -----------------------------------------------------------------
   // Register map and fields
   // -----------------------------------------------------------------
   localparam logic [7:0] REG_ATTR = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_CORE = 8'h08;
   localparam logic [7:0] REG_ISTAT = 8'h0c;
   localparam logic [7:0] REG_ICLR = 8'h10;
   localparam logic [7:0] REG_IEN = 8'h14;
   localparam logic [7:0] REG_STATE = 8'h18;
   localparam int ATTR_CACHE = 0;
   localparam int ATTR_PFEN = 1;
   localparam int CFG_L2_FRZ = 0;
   localparam int CFG_L2_SIZE = 1;
   localparam int CFG_L1_SIZE = 4;
   localparam int CFG_L1_FRZ = 7;
   localparam logic [1:0] ATTR_RST = 2'h0;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [3:0] CORE_RST = 4'h0;

   // -----------------------------------------------------------------
   // Events and classes
   // -----------------------------------------------------------------
   localparam int EV_W = 4;
   localparam int EV_STALE = 0;
   localparam int EV_CANCEL = 1;
   localparam int EV_DROP = 2;
   localparam int EV_WINV = 3;

   typedef enum logic [1:0] {
      K_MISS = 2'b00,
      K_ADDR = 2'b01,
      K_DATA = 2'b10,
      K_WAIT = 2'b11
   } hit_kind_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } dem_state_e;
endpackage

// *** hdl/pf_issue_stage.sv ***
`timescale 1ns/10ps
// One-deep prefetch issue register. A new load while the held request is
// still unaccepted replaces it, and the loser is reported as dropped.
module pf_issue_stage
   import dpb_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic load,
   input wire logic [LINE_W-1:0] load_line,
   input wire logic [SLOT_W-1:0] load_slot,
   input wire logic [GEN_W-1:0] load_gen,
   output logic busy,
   output logic [LINE_W-1:0] out_line,
   output logic [SLOT_W-1:0] out_slot,
   output logic [GEN_W-1:0] out_gen,
   input wire logic out_ready,
   output logic drop,
   output logic [SLOT_W-1:0] drop_slot,
   output logic [GEN_W-1:0] drop_gen
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy <= 1'b0;
         out_line <= '0;
         out_slot <= '0;
         out_gen <= '0;
         drop <= 1'b0;
         drop_slot <= '0;
         drop_gen <= '0;
      end else begin
         drop <= load && busy && !out_ready;
         drop_slot <= out_slot;
         drop_gen <= out_gen;
         if (load) begin
            busy <= 1'b1;
            out_line <= load_line;
            out_slot <= load_slot;
            out_gen <= load_gen;
         end else if (out_ready) begin
            busy <= 1'b0;
         end
      end
   end
endmodule

// *** hdl/data_prefetch_buffer.sv ***
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
module data_prefetch_buffer
   import dpb_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [31:0] req_addr,
   input wire logic req_write,
   input wire logic req_l2,
   output logic rsp_valid,
   output hit_kind_e rsp_kind,
   output logic rsp_fwd,
   output logic [2*DATA_W-1:0] rsp_data,
   output logic pf_valid,
   input wire logic pf_ready,
   output logic [31:0] pf_addr,
   output logic [SLOT_W-1:0] pf_slot,
   output logic [GEN_W-1:0] pf_gen,
   input wire logic ret_valid,
   input wire logic [SLOT_W-1:0] ret_slot,
   input wire logic [GEN_W-1:0] ret_gen,
   input wire logic ret_ok,
   input wire logic [DATA_W-1:0] ret_data,
   output logic irq
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [1:0] attr_r;
   logic [7:0] cfg_r;
   logic [3:0] core_r;
   logic [EV_W-1:0] ist_r, ien_r, ev, clr;
   logic ap_v_r, ap_wr_r;
   logic [7:0] ap_off_r;
   logic [31:0] rd_val;
   logic [ENTRIES-1:0] ent_v_r;
   logic [LINE_W-1:0] ent_base_r [ENTRIES];
   logic [ENT_W-1:0] ptr_r, pf2_e_r, hit_e;
   logic [LINE_W-1:0] cand_r, rq_line, ld_line, stg_line;
   logic cand_v_r, pf2_pend_r;
   logic [SLOTS-1:0] dv_r, os_r;
   logic [GEN_W-1:0] gen_r [SLOTS];
   logic [DATA_W-1:0] dat_r [SLOTS];
   dem_state_e st_r;
   logic [SLOT_W-1:0] w0_r, w1_r, s0, s1, ld_slot, drop_slot;
   logic [GEN_W-1:0] ld_gen, drop_gen;
   logic wl2_r, hit, hit_h, elig, alias_w, direct_w, l1_on, take, rd_take;
   logic dhit, whit, alloc, lookb, winv, pf2_go, ld, stg_busy, drop;
   logic ret_match, wait_done;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   always_comb begin
      rd_val = 32'h00000000;
      unique case (haddr[7:0])
         REG_ATTR: rd_val[1:0] = attr_r;
         REG_CFG: rd_val[7:0] = cfg_r;
         REG_CORE: rd_val[3:0] = core_r;
         REG_ISTAT: rd_val[EV_W-1:0] = ist_r;
         REG_IEN: rd_val[EV_W-1:0] = ien_r;
         REG_STATE: rd_val[15:0] = {ent_v_r, 1'b0, st_r, 1'b0, pf2_pend_r, 1'b0, ptr_r};
         default: rd_val = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_v_r <= 1'b0;
         ap_wr_r <= 1'b0;
         ap_off_r <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ap_v_r <= hsel && hready && htrans[1];
         ap_wr_r <= hwrite;
         ap_off_r <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hsel && hready && htrans[1] && !hwrite) begin
            hrdata <= rd_val;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         attr_r <= ATTR_RST;
         cfg_r <= CFG_RST;
         core_r <= CORE_RST;
         ien_r <= '0;
      end else if (ap_v_r && ap_wr_r) begin
         unique case (ap_off_r)
            REG_ATTR: attr_r <= hwdata[1:0];
            REG_CFG: cfg_r <= hwdata[7:0];
            REG_CORE: core_r <= hwdata[3:0];
            REG_IEN: ien_r <= hwdata[EV_W-1:0];
            default: ;
         endcase
      end
   end

   // Set beats clear, so an event landing on the clear write is kept.
   assign clr = (ap_v_r && ap_wr_r && ap_off_r == REG_ICLR) ? hwdata[EV_W-1:0] : '0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ist_r <= '0;
         irq <= 1'b0;
      end else begin
         ist_r <= (ist_r & ~clr) | ev;
         irq <= |(((ist_r & ~clr) | ev) & ien_r);
      end
   end

   // ----------------------------------------------------------------
   // Demand classification
   // ----------------------------------------------------------------
   assign rq_line = req_addr[31:HALF_SHIFT];
   assign alias_w = req_addr[31:28] == ALIAS_HI && req_addr[27:24] == core_r;
   assign direct_w = req_addr >= DIRECT_LO || cfg_r[CFG_L2_FRZ] ||
                     cfg_r[CFG_L2_SIZE +: 3] == 3'h0;
   assign l1_on = cfg_r[CFG_L1_SIZE +: 3] != 3'h0 && !cfg_r[CFG_L1_FRZ];
   assign elig = attr_r[ATTR_CACHE] && attr_r[ATTR_PFEN] &&
                 (req_l2 || (l1_on && direct_w && !alias_w));

   // A level-1 half may sit in either half of an entry; level-2 lines must align.
   always_comb begin
      hit = 1'b0;
      hit_e = '0;
      hit_h = 1'b0;
      for (int i = 0; i < ENTRIES; i++) begin
         if (ent_v_r[i] && (ent_base_r[i] == rq_line ||
             (!req_l2 && ent_base_r[i] + 1'b1 == rq_line))) begin
            hit = 1'b1;
            hit_e = ENT_W'(i);
            hit_h = ent_base_r[i] != rq_line;
         end
      end
   end

   assign s0 = {hit_e, hit_h};
   assign s1 = {hit_e, ~hit_h};
   assign dhit = req_l2 ? dv_r[s0] && dv_r[s1] : dv_r[s0];
   assign whit = req_l2 ? os_r[s0] || os_r[s1] : os_r[s0];
   assign take = req_valid && req_ready;
   assign rd_take = take && !req_write && elig;
   assign alloc = rd_take && !hit && cand_v_r && rq_line == cand_r;
   assign lookb = rd_take && hit && !req_l2 && !dv_r[s1] && !os_r[s1];
   assign winv = take && req_write && hit;
   assign wait_done = !os_r[w0_r] && !(wl2_r && os_r[w1_r]);

   // ----------------------------------------------------------------
   // Prefetch generation
   // ----------------------------------------------------------------
   // The second prefetch of a new stream waits for a free issue stage.
   assign pf2_go = pf2_pend_r && !stg_busy && !alloc && !lookb;
   assign ld = alloc || lookb || pf2_go;

   always_comb begin
      if (alloc) begin
         ld_slot = {ptr_r, 1'b0};
         ld_line = rq_line + 1'b1;
      end else if (lookb) begin
         ld_slot = s1;
         ld_line = hit_h ? ent_base_r[hit_e] : ent_base_r[hit_e] + 1'b1;
      end else begin
         ld_slot = {pf2_e_r, 1'b1};
         ld_line = ent_base_r[pf2_e_r] + 1'b1;
      end
   end

   assign ld_gen = gen_r[ld_slot] + 1'b1;

   pf_issue_stage u_stage (
      .hclk(hclk),
      .hresetn(hresetn),
      .load(ld),
      .load_line(ld_line),
      .load_slot(ld_slot),
      .load_gen(ld_gen),
      .busy(stg_busy),
      .out_line(stg_line),
      .out_slot(pf_slot),
      .out_gen(pf_gen),
      .out_ready(pf_ready),
      .drop(drop),
      .drop_slot(drop_slot),
      .drop_gen(drop_gen)
   );

   assign pf_valid = stg_busy;
   assign pf_addr = {stg_line, 6'h00};

   assign ret_match = os_r[ret_slot] && gen_r[ret_slot] == ret_gen;
   assign ev = {winv, drop, ret_valid && ret_match && !ret_ok,
                ret_valid && !ret_match};

   // ----------------------------------------------------------------
   // Stream entries
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ent_v_r <= '0;
         ptr_r <= '0;
         cand_r <= '0;
         cand_v_r <= 1'b0;
         pf2_pend_r <= 1'b0;
         pf2_e_r <= '0;
         for (int i = 0; i < ENTRIES; i++) begin
            ent_base_r[i] <= '0;
         end
      end else begin
         if (rd_take && !hit) begin
            cand_r <= rq_line + 1'b1;
            cand_v_r <= 1'b1;
         end
         if (pf2_go) begin
            pf2_pend_r <= 1'b0;
         end
         if (alloc) begin
            ent_v_r[ptr_r] <= 1'b1;
            ent_base_r[ptr_r] <= rq_line + 1'b1;
            ptr_r <= ptr_r + 1'b1;
            pf2_pend_r <= 1'b1;
            pf2_e_r <= ptr_r;
         end
      end
   end

   // Later assignments win: a new issue overrides a return or a drop
   // to the same slot. The generation bump retires any older copy,
   // including one leaving the stage on this same edge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dv_r <= '0;
         os_r <= '0;
         for (int i = 0; i < SLOTS; i++) begin
            gen_r[i] <= '0;
            dat_r[i] <= '0;
         end
      end else begin
         if (ret_valid && ret_match) begin
            os_r[ret_slot] <= 1'b0;
            dv_r[ret_slot] <= ret_ok;
            if (ret_ok) begin
               dat_r[ret_slot] <= ret_data;
            end
         end
         if (drop && gen_r[drop_slot] == drop_gen) begin
            os_r[drop_slot] <= 1'b0;
         end
         for (int h = 0; h < 2; h++) begin
            if (winv && (h == 0 || req_l2)) begin
               dv_r[h == 0 ? s0 : s1] <= 1'b0;
               os_r[h == 0 ? s0 : s1] <= 1'b0;
               gen_r[h == 0 ? s0 : s1] <= gen_r[h == 0 ? s0 : s1] + 1'b1;
            end
            if (alloc) begin
               dv_r[{ptr_r, h[0]}] <= 1'b0;
               os_r[{ptr_r, h[0]}] <= 1'b0;
               gen_r[{ptr_r, h[0]}] <= gen_r[{ptr_r, h[0]}] + 1'b1;
            end
         end
         if (ld) begin
            os_r[ld_slot] <= 1'b1;
            dv_r[ld_slot] <= 1'b0;
            gen_r[ld_slot] <= ld_gen;
         end
      end
   end

   // ----------------------------------------------------------------
   // Demand answer
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= ST_IDLE;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_kind <= K_MISS;
         rsp_fwd <= 1'b0;
         rsp_data <= '0;
         w0_r <= '0;
         w1_r <= '0;
         wl2_r <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         unique case (st_r)
            ST_IDLE: begin
               req_ready <= 1'b1;
               if (rd_take && hit && !dhit && whit) begin
                  st_r <= ST_WAIT;
                  req_ready <= 1'b0;
                  w0_r <= s0;
                  w1_r <= s1;
                  wl2_r <= req_l2;
               end else if (take) begin
                  rsp_valid <= 1'b1;
                  rsp_data <= {req_l2 ? dat_r[s1] : {DATA_W{1'b0}}, dat_r[s0]};
                  if (rd_take && hit && dhit) begin
                     rsp_kind <= K_DATA;
                     rsp_fwd <= 1'b0;
                  end else begin
                     rsp_kind <= hit ? K_ADDR : K_MISS;
                     rsp_fwd <= 1'b1;
                  end
               end
            end
            ST_WAIT: begin
               if (wait_done) begin
                  st_r <= ST_IDLE;
                  req_ready <= 1'b1;
                  rsp_valid <= 1'b1;
                  rsp_data <= {wl2_r ? dat_r[w1_r] : {DATA_W{1'b0}}, dat_r[w0_r]};
                  if (dv_r[w0_r] && (!wl2_r || dv_r[w1_r])) begin
                     rsp_kind <= K_WAIT;
                     rsp_fwd <= 1'b0;
                  end else begin
                     rsp_kind <= K_ADDR;
                     rsp_fwd <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_data_hit_served: assert property (
      rd_take && hit && dhit |=> rsp_valid && rsp_kind == K_DATA && !rsp_fwd)
      else $error("data hit not served from buffer");
   a_wait_then_serve: assert property (
      st_r == ST_WAIT && wait_done |=> rsp_valid && st_r == ST_IDLE && req_ready)
      else $error("waiting access not answered");
   a_addr_hit_fwd: assert property (
      rsp_valid && rsp_kind inside {K_ADDR, K_MISS} |-> rsp_fwd)
      else $error("address hit or miss not forwarded");
   a_alloc_ptr_moves: assert property (
      alloc |=> ent_v_r[$past(ptr_r)] && ptr_r == $past(ptr_r) + 3'h1)
      else $error("allocation did not take oldest entry");
   a_collision_drops: assert property (
      ld && stg_busy && !pf_ready |=> drop && pf_slot == $past(ld_slot))
      else $error("earlier prefetch not dropped");
   a_write_inval: assert property (
      winv |=> !dv_r[$past(s0)])
      else $error("write left prefetched data valid");
   a_cancel_no_data: assert property (
      ret_valid && ret_match && !ret_ok && !ld |=> !dv_r[$past(ret_slot)])
      else $error("cancelled return left data");
   a_second_pf_later: assert property (
      alloc |=> pf_valid && !pf_slot[0] && pf2_pend_r &&
      pf_addr[31:6] == $past(rq_line) + 26'h1)
      else $error("stream prefetch order broken");
   a_single_out: assert property (
      ld |=> os_r[$past(ld_slot)] && gen_r[$past(ld_slot)] == $past(ld_gen))
      else $error("prefetch issued without fresh generation");
   a_same_edge_stale: assert property (
      ld && pf_valid && pf_ready && pf_slot == ld_slot |=> pf_gen != $past(pf_gen) ||
      gen_r[$past(ld_slot)] != $past(pf_gen))
      else $error("leaving prefetch not made stale");
   a_alias_blocked: assert property (
      take && !req_l2 && alias_w |-> !elig)
      else $error("alias window reached prefetcher");

   c_data_hit: cover property (rsp_valid && rsp_kind == K_DATA);
   c_wait_hit: cover property (rsp_valid && rsp_kind == K_WAIT);
   c_lookback: cover property (lookb);
   c_stale_ret: cover property (ret_valid && !ret_match);
endmodule

// *** dv/mem_ctrl_model.sv ***
`timescale 1ns/10ps
// Shared memory controller stand-in. Each prefetch is answered after a
// programmable delay, or at once if it is oldest while more than CAP wait, with data equal to its own address.
module mem_ctrl_model
   import dpb_pkg::*;
#(
   parameter int CAP = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic stall,
   input wire logic ok,
   input wire logic [31:0] delay,
   input wire logic pf_valid,
   output logic pf_ready,
   input wire logic [31:0] pf_addr,
   input wire logic [SLOT_W-1:0] pf_slot,
   input wire logic [GEN_W-1:0] pf_gen,
   output logic ret_valid,
   output logic [SLOT_W-1:0] ret_slot,
   output logic [GEN_W-1:0] ret_gen,
   output logic ret_ok,
   output logic [31:0] ret_data,
   output logic [31:0] last_addr
);
   logic [38:0] q[$];
   int due[$];
   int now;
   assign pf_ready = !stall;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q.delete();
         due.delete();
         now = 0;
         ret_valid <= 1'b0;
         {ret_data, ret_slot, ret_gen, ret_ok} <= 40'h0;
         last_addr <= 32'h0;
      end else begin
         now = now + 1;
         // A holding store with more than CAP entries gives up its oldest prefetch at once.
         if (q.size() > 0 && (due[0] <= now || q.size() > CAP)) begin
            ret_valid <= 1'b1;
            ret_ok <= ok && q.size() <= CAP;
            {ret_data, ret_slot, ret_gen} <= q.pop_front();
            void'(due.pop_front());
         end else begin
            // Idle data, slot and generation lines toggle so a stale value is never mistaken for data; ret_valid stays low and ret_ok holds.
            ret_valid <= 1'b0;
            {ret_data, ret_slot, ret_gen} <= ~{ret_data, ret_slot, ret_gen};
         end
         if (pf_valid && pf_ready) begin
            q.push_back({pf_addr, pf_slot, pf_gen});
            due.push_back(now + delay);
            last_addr <= pf_addr;
         end
      end
   end
endmodule

// *** dv/data_prefetch_buffer_tb.sv ***
`timescale 1ns/10ps
module data_prefetch_buffer_tb
   import dpb_pkg::*;
;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, req_valid = 0, req_write = 0;
   logic req_l2 = 0, stall = 0, ok = 1;
   logic [31:0] haddr = 0, hwdata = 0, req_addr = 0, hrdata, pf_addr, ret_data, last_addr, t;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, req_ready, rsp_valid, rsp_fwd, pf_valid, pf_ready, ret_valid;
   logic ret_ok, irq;
   hit_kind_e rsp_kind;
   logic [63:0] rsp_data;
   logic [SLOT_W-1:0] pf_slot, ret_slot;
   logic [GEN_W-1:0] pf_gen, ret_gen;
   int delay = 2, failures = 0, checks_done = 0;
   always #2.5 hclk = ~hclk;
   data_prefetch_buffer u_data_prefetch_buffer (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
      .req_write(req_write), .req_l2(req_l2), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind),
      .rsp_fwd(rsp_fwd), .rsp_data(rsp_data), .pf_valid(pf_valid), .pf_ready(pf_ready),
      .pf_addr(pf_addr), .pf_slot(pf_slot), .pf_gen(pf_gen), .ret_valid(ret_valid),
      .ret_slot(ret_slot), .ret_gen(ret_gen), .ret_ok(ret_ok), .ret_data(ret_data),
      .irq(irq));
   mem_ctrl_model u_mem_ctrl_model (.hclk(hclk), .hresetn(hresetn), .stall(stall),
      .ok(ok), .delay(delay), .pf_valid(pf_valid), .pf_ready(pf_ready), .pf_addr(pf_addr),
      .pf_slot(pf_slot), .pf_gen(pf_gen), .ret_valid(ret_valid), .ret_slot(ret_slot),
      .ret_gen(ret_gen), .ret_ok(ret_ok), .ret_data(ret_data), .last_addr(last_addr));

   task end_of_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      t = hrdata;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(t, exp);
   endtask
   // Demand request: held until taken, then waits for its response pulse.
   task dem(input logic [31:0] a, input logic w);
      int n;
      n = 0;
      req_addr <= a;
      req_write <= w;
      req_valid <= 1'b1;
      do begin @(posedge hclk); n++; end while (req_ready !== 1'b1 && n < 50);
      req_valid <= 1'b0;
      do begin @(posedge hclk); n++; end while (rsp_valid !== 1'b1 && n < 200);
      chk(n < 200, 1);
   endtask
   task pair(input logic [31:0] a);
      dem(a, 1'b0);
      dem(a + 32'h40, 1'b0);
      repeat (12) @(posedge hclk);
   endtask

   task t_reset;
      rd(REG_ATTR, 32'h0);
      rd(REG_CFG, 32'h0);
      rd(REG_CORE, 32'h0);
      rd(REG_ISTAT, 32'h0);
      rd(REG_STATE, 32'h0);
      rd(8'h40, 32'h0);
      chk(hresp, 0);
      $display("test reset done");
   endtask
   task t_gate;
      pair(32'h20000000);
      chk({rsp_kind, rsp_fwd}, {K_MISS, 1'b1});
      chk(last_addr, 32'h0);
      ahb(1'b1, REG_ATTR, 32'h3);
      ahb(1'b1, REG_CFG, 32'h10);
      ahb(1'b1, REG_CORE, 32'h2);
      pair(32'h12000000);
      chk(last_addr, 32'h0);
      $display("test gating done");
   endtask
   task t_stream;
      pair(32'h24000000);
      chk(last_addr, 32'h240000c0);
      dem(32'h240000c0, 1'b0);
      chk({rsp_kind, rsp_fwd}, {K_DATA, 1'b0});
      chk(rsp_data, {32'h0, 32'h240000c0});
      dem(32'h240000c0, 1'b1);
      dem(32'h240000c0, 1'b0);
      chk({rsp_kind, rsp_fwd}, {K_ADDR, 1'b1});
      ahb(1'b1, REG_IEN, 32'h8);
      rd(REG_ISTAT, 32'h8);
      chk(irq, 1);
      ahb(1'b1, REG_IEN, 32'h0);
      repeat (2) @(posedge hclk);
      chk(irq, 0);
      ahb(1'b1, REG_IEN, 32'h8);
      ahb(1'b1, REG_ICLR, 32'hff);
      @(posedge hclk);
      chk(irq, 0);
      $display("test stream done");
   endtask
   task t_wait_fail;
      delay <= 20;
      dem(32'h30000000, 1'b0);
      dem(32'h30000040, 1'b0);
      dem(32'h30000080, 1'b0);
      chk({rsp_kind, rsp_data[31:0]}, {K_WAIT, 32'h30000080});
      delay <= 2;
      ok <= 1'b0;
      pair(32'h40000000);
      dem(32'h400000c0, 1'b0);
      chk({rsp_kind, rsp_fwd}, {K_ADDR, 1'b1});
      ok <= 1'b1;
      $display("test wait and fail done");
   endtask
   task t_drop;
      ahb(1'b1, REG_ICLR, 32'hff);
      stall <= 1'b1;
      pair(32'h50000000);
      pair(32'h60000000);
      chk(pf_valid, 1);
      stall <= 1'b0;
      repeat (12) @(posedge hclk);
      ahb(1'b0, REG_ISTAT, 32'h0);
      chk(t[EV_DROP], 1);
      rd(REG_STATE, 32'h1f05);
      $display("test drop done");
   endtask

   initial begin
      #250000;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset();
      t_gate();
      t_stream();
      t_wait_fail();
      t_drop();
      end_of_test();
   end
endmodule
